// *** clock_monitor_pkg.sv ***
// Constants, register map, field layout and carriers for the audio clock monitor.
// Assumes a 100 MHz system clock and a 32-bit register port with byte addresses, one register every four.
package clock_monitor_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned CLK_HZ = 1000000000 / CLK_PERIOD_NS;
  localparam int unsigned BCLK_TIMEOUT_NS = 2000;
  localparam int unsigned BCLK_TIMEOUT_CYCLES = (BCLK_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned FRAME_SYNC_TIMEOUT_NS = 100000;
  localparam int unsigned FRAME_SYNC_TIMEOUT_CYCLES_DEF = (FRAME_SYNC_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned HALT_UNIT_NS = 1000000;
  localparam int unsigned HALT_UNIT_CYCLES_DEF = (HALT_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RAMP_TICK_NS = 1000;
  localparam int unsigned RAMP_TICK_CYCLES = (RAMP_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RATE_TOL_SHIFT = 4;
  localparam int unsigned NUM_RATES = 6;
  localparam int unsigned FS_48K_FAMILY [NUM_RATES] = '{16000, 24000, 32000, 48000, 96000, 192000};
  localparam int unsigned FS_44K_FAMILY [NUM_RATES] = '{14700, 22050, 29400, 44100, 88200, 176400};
  localparam logic [7:0] GAIN_FULL = 8'hFF;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_INT_STATUS = 8'h08;
  localparam logic [7:0] ADDR_INT_MASK = 8'h0C;
  localparam logic [7:0] ADDR_GAIN = 8'h10;
  localparam int unsigned CTRL_W = 10;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 10'h003;
  localparam int unsigned STATUS_STATE_POS = 5;
  localparam int unsigned STATUS_RATIO_POS = 16;
  localparam int unsigned INT_FAULT_BIT = 0;
  localparam int unsigned INT_HALT_BIT = 1;
  localparam logic [1:0] INT_MASK_RESET = 2'h3;

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic play_enable;
    logic [2:0] halt_timer;
    logic auto_clock_power;
    logic halt_disable;
    logic rate_family_44k1;
    logic [2:0] sample_rate_select;
  } ctrl_t;

  typedef struct packed {
    logic rate_bad;
    logic ratio_bad;
    logic frame_sync_stopped;
    logic bclk_stopped;
  } fault_t;

  typedef enum logic [3:0] {
    ST_OFF = 4'h1,
    ST_RUN = 4'h2,
    ST_FAULT = 4'h4,
    ST_HALT = 4'h8
  } mon_state_t;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  // Expected frame length in system clock cycles; zero for an unused code.
  function automatic logic [15:0] nominal_frame_cycles(input logic fam, input logic [2:0] sel);
    logic [15:0] nom;
    nom = 16'h0000;
    if (sel < 3'(NUM_RATES))
    begin
      nom = fam ? 16'(CLK_HZ / FS_44K_FAMILY[sel]) : 16'(CLK_HZ / FS_48K_FAMILY[sel]);
    end
    return nom;
  endfunction

  function automatic logic period_ok(input logic fam, input logic [2:0] sel, input logic [15:0] cycles);
    logic [15:0] nom;
    logic [15:0] diff;
    nom = nominal_frame_cycles(fam, sel);
    diff = (cycles > nom) ? cycles - nom : nom - cycles;
    return (nom != 16'h0000) && (diff <= (nom >> RATE_TOL_SHIFT));
  endfunction

  function automatic logic ratio_ok(input logic fam, input logic [2:0] sel, input logic [9:0] r);
    logic ok;
    logic odd;
    ok = 1'b0;
    odd = (r == 10'h07D) || (r == 10'h0FA) || (r == 10'h1F4);
    case (r)
      10'h010, 10'h018, 10'h020, 10'h030, 10'h040, 10'h060, 10'h080, 10'h0C0, 10'h100, 10'h180, 10'h200,
      10'h07D, 10'h0FA, 10'h1F4: ok = 1'b1;
      default: ok = 1'b0;
    endcase
    if (!fam)
    begin
      case (sel)
        3'h0: ok = ok && (r >= 10'h020);
        3'h1: ok = ok && (r >= 10'h018);
        3'h2, 3'h3: ok = ok;
        3'h4: ok = ok && (r <= 10'h100);
        3'h5: ok = ok && (r <= 10'h080);
        default: ok = 1'b0;
      endcase
    end
    else
    begin
      ok = ok && !odd;
      case (sel)
        3'h0: ok = ok && (r >= 10'h030);
        3'h1: ok = ok && (r >= 10'h020);
        3'h2: ok = ok && (r >= 10'h018);
        3'h3: ok = ok;
        3'h4: ok = ok && (r <= 10'h180);
        3'h5: ok = ok && (r <= 10'h0C0);
        default: ok = 1'b0;
      endcase
    end
    return ok;
  endfunction

endpackage

// *** pin_edge_sync.sv ***
// Two-stage synchroniser with a rising-edge detector for one external pin.
// Assumes the pin toggles slower than a quarter of the system clock.
`timescale 1ns/1ps
`default_nettype none
module pin_edge_sync (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic pin_in,
  output logic rise
);
  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
  } sync_state_t;

  sync_state_t s_r;
  sync_state_t s_nxt;

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.meta = pin_in;
    s_nxt.sync = s_r.meta;
    s_nxt.prev = s_r.sync;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign rise = s_r.sync & ~s_r.prev;
endmodule
`default_nettype wire

// *** edge_watchdog.sv ***
// Timeout counter that flags a stopped clock when no edge is seen in time.
// Assumes edge_seen is a one-cycle pulse on the system clock.
`timescale 1ns/1ps
`default_nettype none
module edge_watchdog #(
  parameter int unsigned TIMEOUT = 200
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic edge_seen,
  output logic stopped
);
  localparam int unsigned CNT_W = $clog2(TIMEOUT + 1);

  if (TIMEOUT < 2)
  begin
    $error("edge_watchdog needs a timeout of at least two cycles.");
  end

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic stopped;
  } wd_state_t;

  wd_state_t s_r;
  wd_state_t s_nxt;

  // Restarts on every edge and reports a stop once the count runs out.
  always_comb
  begin
    s_nxt = s_r;
    if (edge_seen)
    begin
      s_nxt.cnt = '0; // [R15]
      s_nxt.stopped = 1'b0;
    end
    else if (s_r.cnt == CNT_W'(TIMEOUT - 1))
    begin
      s_nxt.stopped = 1'b1; // [R11]
    end
    else
    begin
      s_nxt.cnt = s_r.cnt + 1'b1; // [R15]
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      s_r <= '{cnt: '0, stopped: 1'b1};
    else
      s_r <= s_nxt;
  end

  assign stopped = s_r.stopped;
endmodule
`default_nettype wire

// *** audio_clock_monitor.sv ***
// Serial audio clock monitor: checks bit clock and frame sync, ramps, halts and powers the amplifier.
// Assumes a 100 MHz clk, a register port with read data one cycle after the strobe, async pins.
//
// What this block does and what it expects of the host
// R1: Timing base is the incoming bit clock.
// R2: Rate field plus valid ratio suffices.
// R3: Flag wrong bit clock rate or ratio.
// R4: Ramp gain down on clock error.
// R5: Halt after timed delay unless halt disabled.
// R6: Auto clock power follows clock validity.
// R7: Host keeps sample rate fixed under auto.
// R8: Software keeps halt disable low under auto.
// R9: 48k family accepts only listed ratio pairs.
// R10: 44.1k family excludes 125, 250, 500.
// R11: Stopped bit clock or frame sync faults.
// R12: Fast shutdown, then ramp back afterwards.
// R13: Unmasked fault pulls interrupt low, reports both.
// R14: Count bit clocks per frame, check ratio.
// R15: Edge-restarted timeout detects a halted clock.
`timescale 1ns/1ps
`default_nettype none
module audio_clock_monitor
  import clock_monitor_pkg::*;
#(
  parameter int unsigned FRAME_SYNC_TIMEOUT_CYCLES = FRAME_SYNC_TIMEOUT_CYCLES_DEF,
  parameter int unsigned HALT_UNIT_CYCLES = HALT_UNIT_CYCLES_DEF
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic serial_bit_clock,
  input wire logic frame_sync,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic interrupt_out_n,
  output logic amp_power_on,
  output logic halt_active,
  output logic [7:0] playback_gain
);
  localparam int unsigned UNIT_W = $clog2(HALT_UNIT_CYCLES + 1);
  localparam int unsigned RAMP_W = $clog2(RAMP_TICK_CYCLES + 1);

  if (FRAME_SYNC_TIMEOUT_CYCLES < BCLK_TIMEOUT_CYCLES || HALT_UNIT_CYCLES < 2)
  begin
    $error("audio_clock_monitor timeout parameters are out of range.");
  end

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    ctrl_t ctrl;
    logic [1:0] int_stat;
    logic [1:0] int_mask;
    mon_state_t st;
    logic [7:0] gain;
    logic [9:0] bclk_cnt;
    logic [15:0] frame_cnt;
    logic [9:0] ratio;
    logic ratio_bad;
    logic rate_bad;
    logic frame_seen;
    logic [UNIT_W-1:0] unit_cnt;
    logic [7:0] halt_units;
    logic [RAMP_W-1:0] ramp_cnt;
    logic [31:0] rdata;
    logic irq_n;
    logic amp_on;
    logic halt_out;
  } mon_t;

  mon_t s_r;
  mon_t s_nxt;
  logic bclk_rise;
  logic frame_sync_rise;
  fault_t fault;
  logic fault_now;
  logic want_power;
  logic [7:0] gain_target;

  // ----------------------------------------------------------------------
  // Pin capture and stop detection
  // ----------------------------------------------------------------------
  pin_edge_sync bclk_sync (
    .clk(clk),
    .rst_b(rst_b),
    .pin_in(serial_bit_clock),
    .rise(bclk_rise)
  );

  pin_edge_sync frame_sync_sync (
    .clk(clk),
    .rst_b(rst_b),
    .pin_in(frame_sync),
    .rise(frame_sync_rise)
  );

  edge_watchdog #(
    .TIMEOUT(BCLK_TIMEOUT_CYCLES)
  ) bclk_watch (
    .clk(clk),
    .rst_b(rst_b),
    .edge_seen(bclk_rise),
    .stopped(fault.bclk_stopped)
  );

  edge_watchdog #(
    .TIMEOUT(FRAME_SYNC_TIMEOUT_CYCLES)
  ) frame_sync_watch (
    .clk(clk),
    .rst_b(rst_b),
    .edge_seen(frame_sync_rise),
    .stopped(fault.frame_sync_stopped)
  );

  assign fault.ratio_bad = s_r.ratio_bad;
  assign fault.rate_bad = s_r.rate_bad;
  assign fault_now = (|fault) | ~s_r.frame_seen; // [R3] [R11]
  assign want_power = s_r.ctrl.auto_clock_power | s_r.ctrl.play_enable; // [R6]
  assign gain_target = (s_r.st == ST_RUN && want_power) ? GAIN_FULL : 8'h00;

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    s_nxt = s_r;

    // Frame measurement driven by bit clock and frame sync edges.
    if (bclk_rise && s_r.bclk_cnt != 10'h3FF)
    begin
      s_nxt.bclk_cnt = s_r.bclk_cnt + 1'b1; // [R1] [R14]
    end
    if (s_r.frame_cnt != 16'hFFFF)
    begin
      s_nxt.frame_cnt = s_r.frame_cnt + 1'b1;
    end
    if (fault.frame_sync_stopped)
    begin
      s_nxt.frame_seen = 1'b0;
    end
    if (frame_sync_rise)
    begin
      s_nxt.ratio = s_r.bclk_cnt;
      s_nxt.ratio_bad = !ratio_ok(s_r.ctrl.rate_family_44k1, s_r.ctrl.sample_rate_select,
                                  s_r.bclk_cnt); // [R3] [R9] [R10] [R14]
      s_nxt.rate_bad = !period_ok(s_r.ctrl.rate_family_44k1, s_r.ctrl.sample_rate_select,
                                  s_r.frame_cnt); // [R2] [R3]
      s_nxt.frame_seen = 1'b1;
      s_nxt.bclk_cnt = bclk_rise ? 10'h001 : 10'h000;
      s_nxt.frame_cnt = 16'h0001;
    end

    // Gain ramp: fast fall, slow rise.
    if (s_r.gain > gain_target)
    begin
      s_nxt.gain = s_r.gain - 1'b1; // [R4] [R12]
      s_nxt.ramp_cnt = '0;
    end
    else if (s_r.gain < gain_target)
    begin
      if (s_r.ramp_cnt == RAMP_W'(RAMP_TICK_CYCLES - 1))
      begin
        s_nxt.ramp_cnt = '0;
        s_nxt.gain = s_r.gain + 1'b1; // [R12]
      end
      else
      begin
        s_nxt.ramp_cnt = s_r.ramp_cnt + 1'b1;
      end
    end
    else
    begin
      s_nxt.ramp_cnt = '0;
    end

    // Power and halt sequencing.
    case (s_r.st)
      ST_OFF:
      begin
        if (want_power && !fault_now)
        begin
          s_nxt.st = ST_RUN; // [R6]
        end
      end
      ST_RUN:
      begin
        if (fault_now)
        begin
          s_nxt.st = ST_FAULT; // [R12]
        end
        else if (!want_power && s_r.gain == 8'h00)
        begin
          s_nxt.st = ST_OFF;
        end
      end
      ST_FAULT:
      begin
        if (!fault_now)
        begin
          s_nxt.st = ST_RUN; // [R12]
          s_nxt.unit_cnt = '0;
          s_nxt.halt_units = 8'h00;
        end
        else if (!s_r.ctrl.halt_disable)
        begin
          if (s_r.halt_units == (8'h01 << s_r.ctrl.halt_timer))
          begin
            s_nxt.st = ST_HALT; // [R5] [R6]
            s_nxt.unit_cnt = '0;
            s_nxt.halt_units = 8'h00;
          end
          else if (s_r.unit_cnt == UNIT_W'(HALT_UNIT_CYCLES - 1))
          begin
            s_nxt.unit_cnt = '0;
            s_nxt.halt_units = s_r.halt_units + 1'b1; // [R5]
          end
          else
          begin
            s_nxt.unit_cnt = s_r.unit_cnt + 1'b1;
          end
        end
      end
      ST_HALT:
      begin
        if (want_power && !fault_now)
        begin
          s_nxt.st = ST_RUN; // [R6]
        end
      end
      default:
      begin
        s_nxt.st = ST_OFF;
      end
    endcase

    // Register writes.
    if (reg_wr)
    begin
      case (reg_addr)
        ADDR_CTRL: s_nxt.ctrl = ctrl_t'(reg_wdata[CTRL_W-1:0]); // [R2]
        ADDR_INT_MASK: s_nxt.int_mask = reg_wdata[1:0];
        default: s_nxt.int_mask = s_nxt.int_mask;
      endcase
    end

    // Register reads; reading the interrupt status clears it, new events win.
    s_nxt.rdata = 32'h00000000;
    if (reg_rd)
    begin
      case (reg_addr)
        ADDR_CTRL: s_nxt.rdata = {22'h000000, s_r.ctrl};
        ADDR_STATUS: s_nxt.rdata = {6'h00, s_r.ratio, 7'h00, s_r.st, fault, fault_now}; // [R13]
        ADDR_INT_STATUS: s_nxt.rdata = {30'h00000000, s_r.int_stat}; // [R13]
        ADDR_INT_MASK: s_nxt.rdata = {30'h00000000, s_r.int_mask};
        ADDR_GAIN: s_nxt.rdata = {24'h000000, s_r.gain};
        default: s_nxt.rdata = 32'h00000000;
      endcase
      if (reg_addr == ADDR_INT_STATUS)
      begin
        s_nxt.int_stat = 2'h0;
      end
    end
    if (fault_now)
    begin
      s_nxt.int_stat[INT_FAULT_BIT] = 1'b1; // [R13]
    end
    if (s_r.st == ST_FAULT && s_nxt.st == ST_HALT)
    begin
      s_nxt.int_stat[INT_HALT_BIT] = 1'b1;
    end

    // Output flops.
    s_nxt.irq_n = ~|(s_nxt.int_stat & ~s_nxt.int_mask); // [R13]
    s_nxt.amp_on = (s_nxt.st == ST_RUN) || (s_nxt.st == ST_FAULT); // [R6]
    s_nxt.halt_out = (s_nxt.st == ST_HALT); // [R5]
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s_r <= '0;
      s_r.ctrl <= ctrl_t'(CTRL_RESET);
      s_r.int_mask <= INT_MASK_RESET;
      s_r.st <= ST_OFF;
      s_r.irq_n <= 1'b1;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign reg_rdata = s_r.rdata;
  assign interrupt_out_n = s_r.irq_n;
  assign amp_power_on = s_r.amp_on;
  assign halt_active = s_r.halt_out;
  assign playback_gain = s_r.gain;
endmodule
`default_nettype wire

// *** audio_clock_monitor_properties.sv ***
// Concurrent checks on the ports of the audio clock monitor.
// Assumes a 100 MHz clk and the register map of the monitor package.
`timescale 1ns/1ps
`default_nettype none
module clock_monitor_checker
  import clock_monitor_pkg::*;
#(
  parameter int unsigned FRAME_SYNC_TIMEOUT_CYCLES = 300
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic serial_bit_clock,
  input wire logic frame_sync,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic interrupt_out_n,
  input wire logic amp_power_on,
  input wire logic halt_active,
  input wire logic [7:0] playback_gain
);
  // --------------------------------------------------------------------
  // Helper logic and properties
  // --------------------------------------------------------------------
  logic bclk_q, fs_q, clr_d1, clr_d2;
  logic [15:0] bclk_idle, fs_idle;
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      bclk_q <= 1'b0;
      fs_q <= 1'b0;
      clr_d1 <= 1'b0;
      clr_d2 <= 1'b0;
      bclk_idle <= 16'h0000;
      fs_idle <= 16'h0000;
    end
    else
    begin
      bclk_q <= serial_bit_clock;
      fs_q <= frame_sync;
      clr_d1 <= (reg_rd && reg_addr == ADDR_INT_STATUS) || (reg_wr && reg_addr == ADDR_INT_MASK);
      clr_d2 <= clr_d1;
      bclk_idle <= (serial_bit_clock && !bclk_q) ? 16'h0000 : bclk_idle + {15'h0000, ~&bclk_idle};
      fs_idle <= (frame_sync && !fs_q) ? 16'h0000 : fs_idle + {15'h0000, ~&fs_idle};
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0) else $error("read data not idle");
  AST_GAIN_FALL_STEP: assert property ((playback_gain < $past(playback_gain))
    |-> playback_gain == $past(playback_gain) - 8'h01) else $error("gain fell too fast");
  AST_GAIN_RISE_STEP: assert property ((playback_gain > $past(playback_gain))
    |-> playback_gain == $past(playback_gain) + 8'h01 && amp_power_on) else $error("bad gain rise");
  AST_GAIN_RISE_GAP: assert property ((playback_gain > $past(playback_gain))
    |=> !(playback_gain > $past(playback_gain))[*8]) else $error("gain rose too fast");
  AST_IRQ_RELEASE: assert property ($rose(interrupt_out_n) |-> clr_d1 || clr_d2) else $error("irq released");
  AST_HALT_ENTRY: assert property ($rose(halt_active) |-> $fell(amp_power_on)) else $error("bad halt entry");
  AST_POWER_DOWN: assert property (($fell(amp_power_on) && !halt_active)
    |-> playback_gain == 8'h00) else $error("power down with gain");
  AST_BCLK_STALL: assert property ((bclk_idle > 16'd230)
    |-> playback_gain <= $past(playback_gain)) else $error("gain rises with bit clock stopped");
  AST_FRAME_SYNC_STALL: assert property ((32'(fs_idle) > FRAME_SYNC_TIMEOUT_CYCLES + 30)
    |-> playback_gain <= $past(playback_gain)) else $error("gain rises with frame sync stopped");
  cover property ($rose(halt_active));
  cover property ($fell(interrupt_out_n));
  cover property ($fell(amp_power_on) && !halt_active);
endmodule
bind audio_clock_monitor clock_monitor_checker #(.FRAME_SYNC_TIMEOUT_CYCLES(FRAME_SYNC_TIMEOUT_CYCLES)) i_checker (
  .clk(clk), .rst_b(rst_b), .serial_bit_clock(serial_bit_clock), .frame_sync(frame_sync),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .interrupt_out_n(interrupt_out_n), .amp_power_on(amp_power_on), .halt_active(halt_active),
  .playback_gain(playback_gain));
`default_nettype wire

// *** tdm_host_model.sv ***
// Host model that drives the bit clock and frame sync at an 80 ns bit period.
// Assumes the bench changes its controls only while it waits on frames.
`timescale 1ns/1ps
`default_nettype none
module tdm_host_model (
  input wire logic run,
  input wire logic [9:0] ratio,
  input wire logic hold_frame,
  output logic serial_bit_clock,
  output logic frame_sync
);
  // --------------------------------------------------------------------
  // Clock and frame generation
  // --------------------------------------------------------------------
  int bit_cnt;
  initial
  begin
    serial_bit_clock = 1'b0;
    frame_sync = 1'b0;
    bit_cnt = 0;
    forever
    begin
      #40;
      if (run)
      begin
        serial_bit_clock = ~serial_bit_clock;
        if (!serial_bit_clock)
        begin
          frame_sync = (bit_cnt == 0) && !hold_frame;
          bit_cnt = (bit_cnt + 1 >= int'(ratio)) ? 0 : bit_cnt + 1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** audio_clock_monitor_bench.sv ***
// Self-checking bench for the audio clock monitor.
// Assumes the checker is bound and the host model drives the pins.
`timescale 1ns/1ps
`default_nettype none
module audio_clock_monitor_bench;
  import clock_monitor_pkg::*;
  // --------------------------------------------------------------------
  // Stimulus and checks
  // --------------------------------------------------------------------
  localparam int unsigned FS_TO = 5000;
  localparam logic [9:0] RATIOS [15] = '{10'h010, 10'h018, 10'h020, 10'h030, 10'h040, 10'h060, 10'h07D,
    10'h080, 10'h0C0, 10'h0FA, 10'h100, 10'h180, 10'h1F4, 10'h200, 10'h0C8};
  logic clk, rst_b, serial_bit_clock, frame_sync, reg_wr, reg_rd, interrupt_out_n, amp_power_on, halt_active;
  logic run, hold_frame;
  logic [7:0] reg_addr, playback_gain;
  logic [31:0] reg_wdata, reg_rdata, rd_val, lfsr;
  logic [9:0] ratio;
  logic [3:0] exp_st;
  int num_errors, comparisons, cycles;
  audio_clock_monitor #(.FRAME_SYNC_TIMEOUT_CYCLES(FS_TO), .HALT_UNIT_CYCLES(10)) i_dut (.clk(clk), .rst_b(rst_b),
    .serial_bit_clock(serial_bit_clock), .frame_sync(frame_sync), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .interrupt_out_n(interrupt_out_n),
    .amp_power_on(amp_power_on), .halt_active(halt_active), .playback_gain(playback_gain));
  tdm_host_model i_host (.run(run), .ratio(ratio), .hold_frame(hold_frame),
    .serial_bit_clock(serial_bit_clock), .frame_sync(frame_sync));
  initial clk = 1'b0;
  always #5 clk = ~clk;
  task automatic test_done();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 95000)
    begin
      num_errors++;
      test_done();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    comparisons++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t %s: got %h want %h", $time, what, seen, exp);
    end
  endtask
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_read(input logic [7:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    rd_val = reg_rdata;
  endtask
  function automatic logic [31:0] lfsr_next(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic exp_ok(input logic fam, input logic [2:0] sel, input logic [9:0] r);
    logic ok;
    int nom, per;
    ok = 1'b0;
    if (sel > 3'h5)
      return 1'b0;
    for (int i = 0; i < 14; i++)
      ok = ok || (r == RATIOS[i]);
    if (fam)
      ok = ok && !(r inside {10'h07D, 10'h0FA, 10'h1F4}) && r >= (sel == 0 ? 48 : sel == 1 ? 32 : sel == 2 ? 24 : 16)
        && r <= (sel == 4 ? 384 : sel == 5 ? 192 : 512);
    else
      ok = ok && r >= (sel == 0 ? 32 : sel == 1 ? 24 : 16) && r <= (sel == 4 ? 256 : sel == 5 ? 128 : 512);
    nom = CLK_HZ / (fam ? FS_44K_FAMILY[sel] : FS_48K_FAMILY[sel]);
    per = 8 * int'(r);
    return ok && ((per > nom ? per - nom : nom - per) <= nom / 16);
  endfunction
  task automatic trial(input logic fam, input logic [2:0] sel, input logic [9:0] r);
    logic ok;
    ok = exp_ok(fam, sel, r);
    reg_write(ADDR_CTRL, {22'h0, 4'h8, 2'h1, fam, sel});
    ratio <= r;
    repeat (16 * int'(r) + 400) @(posedge clk);
    reg_read(ADDR_STATUS);
    exp_st = ok ? 4'h2 : ((exp_st == 4'h1) ? 4'h1 : 4'h4);
    check({31'h0, rd_val[0]}, {31'h0, !ok}, "live fault");
    check({28'h0, rd_val[8:5]}, {28'h0, exp_st}, "state");
    if (ok)
      check({22'h0, rd_val[25:16]}, {22'h0, r}, "ratio");
  endtask
  initial
  begin
    {rst_b, reg_wr, reg_rd, hold_frame, reg_addr, reg_wdata} = '0;
    run = 1'b1;
    ratio = 10'h100;
    lfsr = 32'he70f;
    exp_st = 4'h1;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    reg_read(ADDR_CTRL);
    check(rd_val, {22'h0, CTRL_RESET}, "ctrl reset");
    reg_read(ADDR_INT_MASK);
    check(rd_val, {30'h0, INT_MASK_RESET}, "mask reset");
    reg_read(8'h14);
    check(rd_val, 32'h0, "unmapped");
    trial(1'b0, 3'h3, 10'h100);
    trial(1'b0, 3'h5, 10'h040);
    trial(1'b0, 3'h5, 10'h100);
    reg_write(ADDR_INT_MASK, 32'h0);
    repeat (3) @(posedge clk);
    check({31'h0, interrupt_out_n}, 32'h0, "irq low");
    reg_read(ADDR_INT_STATUS);
    check({31'h0, rd_val[0]}, 32'h1, "latched fault");
    reg_write(ADDR_INT_MASK, 32'h1);
    reg_read(ADDR_INT_STATUS);
    repeat (3) @(posedge clk);
    check({31'h0, interrupt_out_n}, 32'h1, "irq masked");
    reg_write(ADDR_INT_MASK, 32'h3);
    trial(1'b1, 3'h3, 10'h0FA);
    trial(1'b0, 3'h6, 10'h100);
    trial(1'b0, 3'h1, 10'h200);
    repeat (3)
    begin
      lfsr = lfsr_next(lfsr);
      trial(lfsr[3], lfsr[6:4], RATIOS[lfsr[15:8] % 15]);
    end
    trial(1'b0, 3'h3, 10'h100);
    check({31'h0, halt_active}, 32'h0, "no halt when disabled");
    reg_write(ADDR_CTRL, 32'h243);
    hold_frame <= 1'b1;
    for (int i = 0; i < 8000 && halt_active !== 1'b1; i++) @(posedge clk);
    check({30'h0, halt_active, amp_power_on}, 32'h2, "halt on stopped frame");
    reg_read(ADDR_INT_STATUS);
    check({31'h0, rd_val[1]}, 32'h1, "halt event");
    hold_frame <= 1'b0;
    repeat (6544) @(posedge clk);
    check({30'h0, halt_active, amp_power_on}, 32'h1, "resumed");
    reg_write(ADDR_CTRL, 32'h023);
    run <= 1'b0;
    for (int i = 0; i < 2000 && halt_active !== 1'b1; i++) @(posedge clk);
    check({31'h0, halt_active}, 32'h1, "halt on stopped bit clock");
    run <= 1'b1;
    repeat (6544) @(posedge clk);
    check({31'h0, amp_power_on}, 32'h1, "auto power up");
    reg_write(ADDR_CTRL, 32'h003);
    repeat (400) @(posedge clk);
    check({31'h0, amp_power_on}, 32'h0, "power down");
    check({24'h0, playback_gain}, 32'h0, "gain ramped out");
    test_done();
  end
endmodule
`default_nettype wire
